/* src/dual_bank_register_decode.sv */
// Register decode and storage for the eight-channel line interface, both banks.
// Assumes host strobes and channel status are synchronous to mclk_in.
//
// What this block does
// RULE_01 - Every access decodes exactly five address bits.
// RULE_02 - Non-multiplexed mode takes address from dedicated lines.
// RULE_03 - Multiplexed mode takes address from bus bits 4:0.
// RULE_04 - Serial mode takes address from command bits 5:1.
// RULE_05 - Bank pointer at 1F, reachable from both banks.
// RULE_06 - Pointer value AA selects the expanded bank.
// RULE_07 - Pointer cleared to zero selects the primary bank.
// RULE_08 - Primary addresses 16 to 1E are reserved.
// RULE_09 - Expanded test registers reset to zero; software keeps zero.
// RULE_10 - Status registers are read-only live per-channel conditions.
// RULE_11 - Three read/write interrupt mask registers exist.
// RULE_12 - Three read-only interrupt flag registers, paired with masks.
// RULE_13 - Template select reached through index register at 10.
// RULE_14 - Masked status change either way sets flag, asserts interrupt.
// RULE_15 - Reading a status register clears its interrupt flags.
// RULE_16 - Other pointer values mean primary; reserved reads zero.
// RULE_17 - Higher address bits ignored; accesses alias in 32 locations.
`timescale 1ns/1ps
`include "lineif_regs_map.svh"

module dual_bank_register_decode #(
  // Arbitrary neutral value, not a real part code.
  parameter logic [7:0] CHIP_CODE = 8'h5a
) (
  input wire logic mclk_in, // System clock, 200 MHz.
  input wire logic sys_rst_in, // Synchronous reset, active high.
  input wire lineif_pkg::host_mode_t host_mode_in, // Active host interface variant.
  input wire logic [7:0] addr_pins_in, // Dedicated address lines.
  input wire logic [7:0] ad_bus_in, // Shared address/data bus.
  input wire logic addr_latch_in, // Address phase strobe of shared bus.
  input wire logic [7:0] serial_cmd_in, // Serial command byte.
  input wire lineif_pkg::host_access_t access_in, // Access strobe, direction, write data.
  input wire logic [`NUM_CH-1:0] signal_loss_in, // Live loss-of-signal per channel.
  input wire logic [`NUM_CH-1:0] driver_fault_in, // Live driver fault per channel.
  input wire logic [`NUM_CH-1:0] alarm_ind_in, // Live alarm indication per channel.
  output logic [`DATA_W-1:0] rd_data_out, // Read data, registered.
  output logic rd_valid_out, // Pulse: read data valid.
  output logic irq_drive_out, // Interrupt pin level when driven, always low.
  output logic irq_oe_out, // Interrupt pin enable, high while pending.
  output logic soft_reset_out, // Pulse: software reset written.
  output logic expanded_sel_out, // Level: expanded bank selected.
  output lineif_pkg::line_cfg_t line_cfg_out, // Primary configuration registers.
  output logic [15:0][`DATA_W-1:0] exp_cfg_out, // Expanded registers 00 to 0F.
  output logic [`NUM_CH-1:0][`DATA_W-1:0] template_out // Template select per channel.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address and bank selection.

  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] bank_ptr_reg;
  logic expanded;
  logic wr_stb;
  logic rd_stb;
  logic ptr_hit;
  logic prim_wr;
  logic exp_wr;
  logic rst_all;
  logic soft_rst_reg;

  reg_addr_select u_addr (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .mode_in(host_mode_in),
    .addr_pins_in(addr_pins_in),
    .ad_bus_in(ad_bus_in),
    .addr_latch_in(addr_latch_in),
    .serial_cmd_in(serial_cmd_in),
    .addr_out(addr) // RULE_01 RULE_17
  );

  // Any pointer value except the key keeps the primary bank in view.
  assign expanded = (bank_ptr_reg == `BANK_KEY_EXPANDED); // RULE_06 RULE_07 RULE_16
  assign wr_stb = access_in.strobe && access_in.write;
  assign rd_stb = access_in.strobe && !access_in.write;
  assign ptr_hit = (addr == `OFF_BANK_SELECT_POINTER); // RULE_05
  assign prim_wr = wr_stb && !expanded && !ptr_hit;
  assign exp_wr = wr_stb && expanded && !ptr_hit;
  // Software reset restores every register, the bank pointer included.
  assign rst_all = sys_rst_in || soft_rst_reg;
  assign expanded_sel_out = expanded;

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      bank_ptr_reg <= `REG_RESET;
    end else if (wr_stb && ptr_hit) begin
      bank_ptr_reg <= access_in.wdata; // RULE_05
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= prim_wr && (addr == `OFF_SOFTWARE_RESET);
    end
  end

  assign soft_reset_out = soft_rst_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Primary configuration registers.

  lineif_pkg::line_cfg_t cfg_reg;
  logic [`DATA_W-1:0] los_mask_reg;
  logic [`DATA_W-1:0] df_mask_reg;
  logic [`DATA_W-1:0] ais_mask_reg;
  logic [`DATA_W-1:0] tmpl_index_reg;

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      cfg_reg <= '0;
    end else if (prim_wr) begin
      case (addr)
        `OFF_ANALOG_LOOPBACK_CFG: cfg_reg.analog_loopback <= access_in.wdata;
        `OFF_REMOTE_LOOPBACK_CFG: cfg_reg.remote_loopback <= access_in.wdata;
        `OFF_TRANSMIT_ALL_ONES_CFG: cfg_reg.transmit_all_ones <= access_in.wdata;
        `OFF_MONITOR_SELECT: cfg_reg.monitor_select <= access_in.wdata;
        `OFF_DIGITAL_LOOPBACK_CFG: cfg_reg.digital_loopback <= access_in.wdata;
        `OFF_UNLABELED_CONFIG_0D: cfg_reg.unlabeled_0d <= access_in.wdata;
        `OFF_AUTO_ALL_ONES_CFG: cfg_reg.auto_all_ones <= access_in.wdata;
        `OFF_GLOBAL_CONFIG: cfg_reg.global_cfg <= access_in.wdata;
        `OFF_OUTPUT_DRIVE_ENABLE: cfg_reg.output_drive_enable <= access_in.wdata;
        default: cfg_reg <= cfg_reg; // RULE_08 RULE_16
      endcase
    end
  end

  assign line_cfg_out = cfg_reg;

  // Masks default to zero so no cause reaches the pin until software opts in.
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      los_mask_reg <= `REG_RESET;
      df_mask_reg <= `REG_RESET;
      ais_mask_reg <= `REG_RESET;
    end else if (prim_wr) begin
      if (addr == `OFF_SIGNAL_LOSS_IRQ_MASK) begin
        los_mask_reg <= access_in.wdata; // RULE_11
      end
      if (addr == `OFF_DRIVER_FAULT_IRQ_MASK) begin
        df_mask_reg <= access_in.wdata; // RULE_11
      end
      if (addr == `OFF_ALARM_INDICATION_IRQ_MASK) begin
        ais_mask_reg <= access_in.wdata; // RULE_11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect template select: the index picks which channel entry is seen at 11.

  logic [`DATA_W-1:0] tmpl_mem [`NUM_CH];
  logic [2:0] tmpl_sel;

  assign tmpl_sel = tmpl_index_reg[2:0];

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tmpl_index_reg <= `REG_RESET;
    end else if (prim_wr && (addr == `OFF_TEMPLATE_INDEX_POINTER)) begin
      tmpl_index_reg <= access_in.wdata; // RULE_13
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        tmpl_mem[i] <= `REG_RESET;
      end
    end else if (prim_wr && (addr == `OFF_TRANSMIT_TEMPLATE_SELECT)) begin
      tmpl_mem[tmpl_sel] <= access_in.wdata; // RULE_13
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_CH; i++) begin
      template_out[i] = tmpl_mem[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expanded bank storage, locations 00 to 1E; the top location is the pointer.

  logic [`DATA_W-1:0] exp_mem [`NUM_LOC-1];

  // Test locations start at zero and stay writable; software must keep them zero.
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      for (int i = 0; i < `NUM_LOC - 1; i++) begin
        exp_mem[i] <= `REG_RESET; // RULE_09
      end
    end else if (exp_wr) begin
      exp_mem[addr] <= access_in.wdata; // RULE_06
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      exp_cfg_out[i] = exp_mem[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt causes.

  logic [`NUM_CH-1:0] los_flags;
  logic [`NUM_CH-1:0] df_flags;
  logic [`NUM_CH-1:0] ais_flags;
  logic prim_rd;

  assign prim_rd = rd_stb && !expanded;

  irq_cause u_los_irq (
    .mclk_in(mclk_in),
    .rst_in(rst_all),
    .status_in(signal_loss_in),
    .mask_in(los_mask_reg),
    .status_read_in(prim_rd && (addr == `OFF_SIGNAL_LOSS_STATUS)), // RULE_15
    .flags_out(los_flags) // RULE_12 RULE_14
  );

  irq_cause u_df_irq (
    .mclk_in(mclk_in),
    .rst_in(rst_all),
    .status_in(driver_fault_in),
    .mask_in(df_mask_reg),
    .status_read_in(prim_rd && (addr == `OFF_DRIVER_FAULT_STATUS)), // RULE_15
    .flags_out(df_flags) // RULE_12 RULE_14
  );

  irq_cause u_ais_irq (
    .mclk_in(mclk_in),
    .rst_in(rst_all),
    .status_in(alarm_ind_in),
    .mask_in(ais_mask_reg),
    .status_read_in(prim_rd && (addr == `OFF_ALARM_INDICATION_STATUS)), // RULE_15
    .flags_out(ais_flags) // RULE_12 RULE_14
  );

  // The pin is wired-OR with other devices, so it only ever pulls low.
  assign irq_drive_out = 1'b0;
  assign irq_oe_out = |{los_flags, df_flags, ais_flags}; // RULE_14

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [`DATA_W-1:0] prim_rdata;
  logic [`DATA_W-1:0] rdata;

  always_comb begin
    case (addr)
      `OFF_CHIP_CODE: prim_rdata = CHIP_CODE;
      `OFF_ANALOG_LOOPBACK_CFG: prim_rdata = cfg_reg.analog_loopback;
      `OFF_REMOTE_LOOPBACK_CFG: prim_rdata = cfg_reg.remote_loopback;
      `OFF_TRANSMIT_ALL_ONES_CFG: prim_rdata = cfg_reg.transmit_all_ones;
      `OFF_SIGNAL_LOSS_STATUS: prim_rdata = signal_loss_in; // RULE_10
      `OFF_DRIVER_FAULT_STATUS: prim_rdata = driver_fault_in; // RULE_10
      `OFF_SIGNAL_LOSS_IRQ_MASK: prim_rdata = los_mask_reg; // RULE_11
      `OFF_DRIVER_FAULT_IRQ_MASK: prim_rdata = df_mask_reg; // RULE_11
      `OFF_SIGNAL_LOSS_IRQ_FLAGS: prim_rdata = los_flags; // RULE_12
      `OFF_DRIVER_FAULT_IRQ_FLAGS: prim_rdata = df_flags; // RULE_12
      `OFF_MONITOR_SELECT: prim_rdata = cfg_reg.monitor_select;
      `OFF_DIGITAL_LOOPBACK_CFG: prim_rdata = cfg_reg.digital_loopback;
      `OFF_UNLABELED_CONFIG_0D: prim_rdata = cfg_reg.unlabeled_0d;
      `OFF_AUTO_ALL_ONES_CFG: prim_rdata = cfg_reg.auto_all_ones;
      `OFF_GLOBAL_CONFIG: prim_rdata = cfg_reg.global_cfg;
      `OFF_TEMPLATE_INDEX_POINTER: prim_rdata = tmpl_index_reg; // RULE_13
      `OFF_TRANSMIT_TEMPLATE_SELECT: prim_rdata = tmpl_mem[tmpl_sel]; // RULE_13
      `OFF_OUTPUT_DRIVE_ENABLE: prim_rdata = cfg_reg.output_drive_enable;
      `OFF_ALARM_INDICATION_STATUS: prim_rdata = alarm_ind_in; // RULE_10
      `OFF_ALARM_INDICATION_IRQ_MASK: prim_rdata = ais_mask_reg; // RULE_11
      `OFF_ALARM_INDICATION_IRQ_FLAGS: prim_rdata = ais_flags; // RULE_12
      // Software reset is write-only and the reserved range holds nothing.
      default: prim_rdata = `READ_ZERO; // RULE_08 RULE_16
    endcase
  end

  always_comb begin
    if (ptr_hit) begin
      rdata = bank_ptr_reg; // RULE_05
    end else if (expanded) begin
      rdata = exp_mem[addr]; // RULE_06
    end else begin
      rdata = prim_rdata; // RULE_07
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rd_data_out <= `READ_ZERO;
    end else if (rd_stb) begin
      rd_data_out <= rdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_stb;
    end
  end

endmodule // dual_bank_register_decode

/* src/lineif_regs_map.svh */
// Register offsets, reset values and bank key for the line interface register block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LINEIF_REGS_MAP_SVH
`define LINEIF_REGS_MAP_SVH

`define ADDR_W 5
`define DATA_W 8
`define NUM_CH 8
`define NUM_LOC 32

`define OFF_CHIP_CODE 5'h00
`define OFF_ANALOG_LOOPBACK_CFG 5'h01
`define OFF_REMOTE_LOOPBACK_CFG 5'h02
`define OFF_TRANSMIT_ALL_ONES_CFG 5'h03
`define OFF_SIGNAL_LOSS_STATUS 5'h04
`define OFF_DRIVER_FAULT_STATUS 5'h05
`define OFF_SIGNAL_LOSS_IRQ_MASK 5'h06
`define OFF_DRIVER_FAULT_IRQ_MASK 5'h07
`define OFF_SIGNAL_LOSS_IRQ_FLAGS 5'h08
`define OFF_DRIVER_FAULT_IRQ_FLAGS 5'h09
`define OFF_SOFTWARE_RESET 5'h0a
`define OFF_MONITOR_SELECT 5'h0b
`define OFF_DIGITAL_LOOPBACK_CFG 5'h0c
`define OFF_UNLABELED_CONFIG_0D 5'h0d
`define OFF_AUTO_ALL_ONES_CFG 5'h0e
`define OFF_GLOBAL_CONFIG 5'h0f
`define OFF_TEMPLATE_INDEX_POINTER 5'h10
`define OFF_TRANSMIT_TEMPLATE_SELECT 5'h11
`define OFF_OUTPUT_DRIVE_ENABLE 5'h12
`define OFF_ALARM_INDICATION_STATUS 5'h13
`define OFF_ALARM_INDICATION_IRQ_MASK 5'h14
`define OFF_ALARM_INDICATION_IRQ_FLAGS 5'h15
`define OFF_RESERVED_FIRST 5'h16
`define OFF_RESERVED_LAST 5'h1e
`define OFF_EXP_TEST_FIRST 5'h10
`define OFF_BANK_SELECT_POINTER 5'h1f

`define BANK_KEY_EXPANDED 8'haa
`define REG_RESET 8'h00
`define READ_ZERO 8'h00

`endif

/* src/lineif_pkg.sv */
// Types shared by the line interface register block and its helpers.
// Assumes the map header sits on the include path.
`include "lineif_regs_map.svh"

package lineif_pkg;

  typedef enum logic [1:0] {
    HOST_NONMUX,
    HOST_MUX,
    HOST_SERIAL
  } host_mode_t;

  typedef struct packed {
    logic strobe;
    logic write;
    logic [`DATA_W-1:0] wdata;
  } host_access_t;

  typedef struct packed {
    logic [`DATA_W-1:0] analog_loopback;
    logic [`DATA_W-1:0] remote_loopback;
    logic [`DATA_W-1:0] transmit_all_ones;
    logic [`DATA_W-1:0] monitor_select;
    logic [`DATA_W-1:0] digital_loopback;
    logic [`DATA_W-1:0] unlabeled_0d;
    logic [`DATA_W-1:0] auto_all_ones;
    logic [`DATA_W-1:0] global_cfg;
    logic [`DATA_W-1:0] output_drive_enable;
  } line_cfg_t;

endpackage

/* src/reg_addr_select.sv */
// Picks the five-bit register address from the active host interface variant.
// Assumes all host inputs are synchronous to mclk_in.
`timescale 1ns/1ps
`include "lineif_regs_map.svh"

module reg_addr_select (
  input wire logic mclk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset, active high.
  input wire lineif_pkg::host_mode_t mode_in, // Active host interface variant.
  input wire logic [7:0] addr_pins_in, // Dedicated address lines.
  input wire logic [7:0] ad_bus_in, // Shared address/data bus.
  input wire logic addr_latch_in, // Address phase of the shared bus.
  input wire logic [7:0] serial_cmd_in, // Serial command byte.
  output logic [`ADDR_W-1:0] addr_out // Decoded register address.
);

  logic [`ADDR_W-1:0] mux_addr_reg;

  // The shared bus carries data after the address phase, so its address is held.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mux_addr_reg <= '0;
    end else if (addr_latch_in) begin
      mux_addr_reg <= ad_bus_in[4:0]; // RULE_03
    end
  end

  always_comb begin
    case (mode_in)
      lineif_pkg::HOST_NONMUX: addr_out = addr_pins_in[4:0]; // RULE_02
      lineif_pkg::HOST_MUX: addr_out = addr_latch_in ? ad_bus_in[4:0] : mux_addr_reg; // RULE_03
      lineif_pkg::HOST_SERIAL: addr_out = serial_cmd_in[5:1]; // RULE_04
      default: addr_out = addr_pins_in[4:0];
    endcase
  end

endmodule // reg_addr_select

/* src/irq_cause.sv */
// One interrupt cause: per-channel change detect, mask, sticky flags, clear on status read.
// Assumes the status vector is synchronous to mclk_in.
`timescale 1ns/1ps
`include "lineif_regs_map.svh"

module irq_cause (
  input wire logic mclk_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic [`NUM_CH-1:0] status_in, // Live per-channel condition.
  input wire logic [`NUM_CH-1:0] mask_in, // Per-channel enable.
  input wire logic status_read_in, // Pulse: host reads the status register.
  output logic [`NUM_CH-1:0] flags_out // Sticky interrupt flags.
);

  logic [`NUM_CH-1:0] prev_reg;
  logic [`NUM_CH-1:0] change;

  assign change = (status_in ^ prev_reg) & mask_in; // RULE_14

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= status_in;
    end
  end

  // A change in the same cycle as the clearing read survives the clear.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= (status_read_in ? '0 : flags_out) | change; // RULE_15
    end
  end

endmodule // irq_cause

/* tb/dual_bank_register_decode_properties.sv */
// Concurrent checks on the register decode block, seen only through its ports.
// Assumes one clock, mclk_in, and a synchronous active-high reset.
`timescale 1ns/1ps
`include "lineif_regs_map.svh"

module dual_bank_register_decode_properties (
  input wire logic mclk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset.
  input wire lineif_pkg::host_mode_t host_mode_in, // Host variant.
  input wire logic [7:0] addr_pins_in, // Dedicated address lines.
  input wire logic [7:0] ad_bus_in, // Shared bus.
  input wire logic addr_latch_in, // Address phase.
  input wire logic [7:0] serial_cmd_in, // Serial command.
  input wire lineif_pkg::host_access_t access_in, // Access request.
  input wire logic [`NUM_CH-1:0] signal_loss_in, // Loss status.
  input wire logic [`NUM_CH-1:0] driver_fault_in, // Fault status.
  input wire logic [`NUM_CH-1:0] alarm_ind_in, // Alarm status.
  input wire logic [`DATA_W-1:0] rd_data_out, // Read data.
  input wire logic rd_valid_out, // Read valid.
  input wire logic irq_drive_out, // Interrupt level.
  input wire logic irq_oe_out, // Interrupt enable.
  input wire logic soft_reset_out, // Software reset pulse.
  input wire logic expanded_sel_out, // Expanded bank.
  input wire lineif_pkg::line_cfg_t line_cfg_out, // Primary config.
  input wire logic [15:0][`DATA_W-1:0] exp_cfg_out, // Expanded storage.
  input wire logic [`NUM_CH-1:0][`DATA_W-1:0] template_out // Templates.
);
  logic [4:0] latched_addr;
  logic [4:0] dec_addr;
  logic [23:0] prev_stat;
  wire logic rd_req = access_in.strobe && !access_in.write;
  wire logic wr_req = access_in.strobe && access_in.write;
  wire logic ptr_wr = wr_req && (dec_addr == 5'h1f);
  wire logic any_chg = {signal_loss_in, driver_fault_in, alarm_ind_in} != prev_stat;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      latched_addr <= 5'h00;
    end else if (addr_latch_in) begin
      latched_addr <= ad_bus_in[4:0];
    end
  end

  // Mirrors the design's previous sample, which also starts at zero.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      prev_stat <= 24'h000000;
    end else begin
      prev_stat <= {signal_loss_in, driver_fault_in, alarm_ind_in};
    end
  end

  always_comb begin
    case (host_mode_in)
      lineif_pkg::HOST_MUX: dec_addr = addr_latch_in ? ad_bus_in[4:0] : latched_addr;
      lineif_pkg::HOST_SERIAL: dec_addr = serial_cmd_in[5:1];
      default: dec_addr = addr_pins_in[4:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_read_answer: assert property (rd_req |=> rd_valid_out)
    else $error("read strobe without valid");
  chk_valid_cause: assert property (rd_valid_out |-> $past(rd_req))
    else $error("valid without read strobe");
  chk_status_live: assert property ((rd_req && !expanded_sel_out && dec_addr == 5'h04)
    |=> rd_data_out == $past(signal_loss_in)) else $error("status read not live");
  chk_reserved_zero: assert property ((rd_req && !expanded_sel_out
    && dec_addr inside {[5'h16:5'h1e]}) |=> rd_data_out == 8'h00) else $error("reserved nonzero");
  chk_bank_enter: assert property (ptr_wr
    |=> expanded_sel_out == ($past(access_in.wdata) == 8'haa)) else $error("bank select wrong");
  chk_bank_hold: assert property ($changed(expanded_sel_out)
    |-> $past(ptr_wr) || $past(soft_reset_out) || $past(sys_rst_in)) else $error("bank moved");
  chk_cfg_write: assert property ((wr_req && !expanded_sel_out && dec_addr == 5'h01)
    |=> line_cfg_out.analog_loopback == $past(access_in.wdata)) else $error("config lost");
  chk_exp_write: assert property ((wr_req && expanded_sel_out && dec_addr < 5'h10)
    |=> exp_cfg_out[$past(dec_addr[3:0])] == $past(access_in.wdata)) else $error("exp lost");
  chk_irq_cause: assert property ($rose(irq_oe_out) |-> $past(any_chg))
    else $error("interrupt without change");
  chk_irq_release: assert property ($fell(irq_oe_out)
    |-> rd_valid_out || $past(soft_reset_out)) else $error("interrupt cleared unasked");

  cover property (rd_req && expanded_sel_out);
  cover property ($rose(irq_oe_out));
  cover property ($fell(expanded_sel_out));
endmodule // dual_bank_register_decode_properties

bind dual_bank_register_decode dual_bank_register_decode_properties u_chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .host_mode_in(host_mode_in),
  .addr_pins_in(addr_pins_in), .ad_bus_in(ad_bus_in), .addr_latch_in(addr_latch_in),
  .serial_cmd_in(serial_cmd_in), .access_in(access_in), .signal_loss_in(signal_loss_in),
  .driver_fault_in(driver_fault_in), .alarm_ind_in(alarm_ind_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .irq_drive_out(irq_drive_out), .irq_oe_out(irq_oe_out),
  .soft_reset_out(soft_reset_out), .expanded_sel_out(expanded_sel_out),
  .line_cfg_out(line_cfg_out), .exp_cfg_out(exp_cfg_out), .template_out(template_out));

/* tb/host_port_model.sv */
// Host processor model: makes one register access at a time on any host variant.
// Assumes the block answers a read exactly one cycle after the strobe edge.
`timescale 1ns/1ps

module host_port_model (
  input wire logic mclk_in, // System clock.
  input wire logic [7:0] rd_data_in, // Read data.
  input wire logic rd_valid_in, // Read valid.
  output lineif_pkg::host_mode_t host_mode_out, // Host variant.
  output logic [7:0] addr_pins_out, // Dedicated address lines.
  output logic [7:0] ad_bus_out, // Shared bus.
  output logic addr_latch_out, // Address phase.
  output logic [7:0] serial_cmd_out, // Serial command.
  output lineif_pkg::host_access_t access_out // Access request.
);
  initial begin
    host_mode_out = lineif_pkg::HOST_NONMUX;
    addr_pins_out = 8'h00;
    ad_bus_out = 8'h00;
    addr_latch_out = 1'b0;
    serial_cmd_out = 8'h00;
    access_out = '0;
  end

  // Writes latch the address a cycle early; idle variants carry another address.
  task automatic xfer(input lineif_pkg::host_mode_t m, input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge mclk_in);
    host_mode_out <= m;
    addr_pins_out <= {3'b111, (m == lineif_pkg::HOST_NONMUX) ? a : ~a};
    ad_bus_out <= {3'b101, (m == lineif_pkg::HOST_MUX) ? a : ~a};
    addr_latch_out <= 1'b1;
    serial_cmd_out <= {2'b11, (m == lineif_pkg::HOST_SERIAL) ? a : ~a, ~w};
    access_out <= '{strobe: !w, write: w, wdata: d};
    if (w) @(posedge mclk_in) {addr_latch_out, access_out.strobe} <= 2'b01;
    @(posedge mclk_in);
    access_out <= '{strobe: 1'b0, write: ~w, wdata: ~d};
    addr_pins_out <= {3'b000, ~a};
    ad_bus_out <= {3'b010, ~a};
    addr_latch_out <= 1'b0;
    serial_cmd_out <= {2'b00, ~a, w};
    #1;
    q = rd_data_in;
    v = rd_valid_in;
  endtask
endmodule // host_port_model

/* tb/dual_bank_register_decode_bench.sv */
// Self-checking bench for the register decode block, driven through the host model.
// Assumes the host model and the checker bind are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module dual_bank_register_decode_bench;
  localparam logic [7:0] CHIP = 8'h5a; // Arbitrary value, not a real part code.
  logic mclk_in;
  logic sys_rst_in;
  lineif_pkg::host_mode_t host_mode;
  logic [7:0] addr_pins, ad_bus, serial_cmd, rd_data_out;
  logic addr_latch, rd_valid_out, irq_drive_out, irq_oe_out, soft_reset_out, expanded_sel_out;
  lineif_pkg::host_access_t access;
  logic [2:0][7:0] stat;
  lineif_pkg::line_cfg_t line_cfg_out;
  logic [15:0][7:0] exp_cfg_out;
  logic [7:0][7:0] template_out;
  logic [7:0] shadow [32];
  int mismatches = 0;
  int samples_checked = 0;
  int mk [3] = '{6, 7, 20};
  int fl [3] = '{8, 9, 21};
  int st [3] = '{4, 5, 19};

  dual_bank_register_decode #(.CHIP_CODE(CHIP)) u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .host_mode_in(host_mode),
    .addr_pins_in(addr_pins), .ad_bus_in(ad_bus), .addr_latch_in(addr_latch),
    .serial_cmd_in(serial_cmd), .access_in(access), .signal_loss_in(stat[0]),
    .driver_fault_in(stat[1]), .alarm_ind_in(stat[2]), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .irq_drive_out(irq_drive_out), .irq_oe_out(irq_oe_out),
    .soft_reset_out(soft_reset_out), .expanded_sel_out(expanded_sel_out),
    .line_cfg_out(line_cfg_out), .exp_cfg_out(exp_cfg_out), .template_out(template_out));

  host_port_model u_host (
    .mclk_in(mclk_in), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
    .host_mode_out(host_mode), .addr_pins_out(addr_pins), .ad_bus_out(ad_bus),
    .addr_latch_out(addr_latch), .serial_cmd_out(serial_cmd), .access_out(access));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic lineif_pkg::host_mode_t md(input int a);
    return lineif_pkg::host_mode_t'(a % 3);
  endfunction

  function automatic logic [7:0] exp_rd(input int a);
    if (a == 0) return CHIP;
    if (a == 4) return stat[0];
    if (a == 5) return stat[1];
    if (a == 19) return stat[2];
    return shadow[a];
  endfunction

  task automatic wr(input int a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    u_host.xfer(md(a), 1'b1, 5'(a), d, q, v);
    `CHK(v, 1'b0)
  endtask

  task automatic rd_chk(input int m, input int a, input logic [7:0] e);
    logic [7:0] q;
    logic v;
    u_host.xfer(md(m), 1'b0, 5'(a), 8'h00, q, v);
    `CHK(v, 1'b1)
    `CHK(q, e)
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // A hang counts against the run instead of stalling it.
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    end_sim();
  end

  initial begin
    sys_rst_in = 1'b1;
    stat = {8'h96, 8'hc3, 8'h3c};
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 32; a++) rd_chk(a, a, exp_rd(a));
    for (int a = 0; a < 31; a++) begin
      if (a != 10) wr(a, 8'(a * 37 + 5));
      if (a inside {1, 2, 3, 6, 7, [11:18], 20}) shadow[a] = 8'(a * 37 + 5);
    end
    for (int a = 0; a < 32; a++) rd_chk(a + 1, a, exp_rd(a));
    `CHK(line_cfg_out.output_drive_enable, shadow[18])
    for (int c = 0; c < 8; c++) begin
      wr(16, 8'hf8 | 8'(c));
      wr(17, 8'h40 + 8'(c));
    end
    for (int c = 0; c < 8; c++) `CHK(template_out[c], 8'h40 + 8'(c))
    wr(16, 8'h03);
    rd_chk(2, 17, 8'h43);
    for (int c = 0; c < 3; c++) begin
      wr(mk[c], 8'h81);
      for (int k = 0; k < 2; k++) begin
        @(posedge mclk_in);
        stat[c] <= stat[c] ^ 8'(k ? 1 : 3);
        repeat (3) @(posedge mclk_in);
        #1;
        `CHK(irq_oe_out, 1'b1)
        `CHK(irq_drive_out, 1'b0)
        rd_chk(c + k, fl[c], 8'h01);
        rd_chk(c, st[c], stat[c]);
        `CHK(irq_oe_out, 1'b0)
        rd_chk(c + 1, fl[c], 8'h00);
      end
      wr(mk[c], 8'h00);
    end
    wr(31, 8'haa);
    `CHK(expanded_sel_out, 1'b1)
    for (int a = 0; a < 31; a++) rd_chk(a + 2, a, 8'h00);
    for (int a = 0; a < 16; a++) wr(a, 8'h60 + 8'(a));
    for (int a = 0; a < 16; a++) `CHK(exp_cfg_out[a], 8'h60 + 8'(a))
    rd_chk(1, 31, 8'haa);
    for (int k = 0; k < 2; k++) begin
      wr(31, k ? 8'h00 : 8'h55);
      `CHK(expanded_sel_out, 1'b0)
      rd_chk(k, 1, shadow[1]);
      wr(31, 8'haa);
      rd_chk(k + 1, 1, 8'h61);
    end
    wr(31, 8'h00);
    wr(10, 8'hff);
    `CHK(soft_reset_out, 1'b1)
    rd_chk(0, 1, 8'h00);
    rd_chk(1, 6, 8'h00);
    end_sim();
  end
endmodule // dual_bank_register_decode_bench
